/* File: include/spio_defines.svh */
// Register offsets, reset values and constants for the shared parallel I/O port.
// Functional notes
// [R01] Active peripheral drive disables port driver.
// [R02] Idle peripheral leaves pin to port.
// [R03] Direction one means input, zero output.
// [R04] Reset makes every implemented pin input.
// [R05] Latch read returns latch; write updates latch.
// [R06] Pin read returns pins; write updates latch.
// [R07] Unimplemented bits read zero everywhere.
// [R08] Per-pin mux pair selects data and enable.
// [R09] Input-only shared pins have no output mux.
// [R10] Analog pins read zero in pin register.
// [R11] Software sets analog pins as inputs.
// [R12] One cycle between update and read-back.
// [R13] Analog-select input forces pin read zero.
`ifndef SPIO_DEFINES_SVH
`define SPIO_DEFINES_SVH
`define SPIO_OFS_DIR 12'h000
`define SPIO_OFS_LAT 12'h004
`define SPIO_OFS_PIN 12'h008
`define SPIO_OFS_PERIPH 12'h00c
`define SPIO_DIR_RESET 16'hffff
`define SPIO_LAT_RESET 16'h0000
`endif

/* File: include/spio_pkg.sv */
// Types shared by the shared parallel I/O port.
package spio_pkg;
	typedef enum logic [1:0] {
		SPIO_REG_DIR,
		SPIO_REG_LAT,
		SPIO_REG_PIN,
		SPIO_REG_NONE
	} spio_reg_t;
endpackage

/* File: rtl/spio_port.sv */
// Shared parallel I/O port with APB register access and per-pin output muxes.
`timescale 1ns/1ps
`include "spio_defines.svh"
module spio_port import spio_pkg::*; #(
	parameter int WIDTH = 16,
	parameter logic [15:0] IMPL_MASK = 16'hffff,
	parameter logic [15:0] SHARED_MASK = 16'hffff
) (
	// Clock and reset.
	input wire logic CLK_IN,
	input wire logic SRST_IN,
	// APB slave.
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	// Pads.
	input wire logic [WIDTH-1:0] PAD_IN,
	output logic [WIDTH-1:0] PAD_OUT,
	output logic [WIDTH-1:0] PAD_OE_OUT,
	// Peripheral side.
	input wire logic [WIDTH-1:0] PERIPH_EN_IN,
	input wire logic [WIDTH-1:0] PERIPH_DRIVE_IN,
	input wire logic [WIDTH-1:0] PERIPH_DATA_IN,
	// Converter configuration.
	input wire logic [WIDTH-1:0] ANALOG_PIN_SELECT_IN
);
	////////////////////////////////////////////////////////////////////////////////
	localparam logic [WIDTH-1:0] IMPL = IMPL_MASK[WIDTH-1:0];
	localparam logic [WIDTH-1:0] SHARED = SHARED_MASK[WIDTH-1:0];
	localparam logic [WIDTH-1:0] DIR_RST = WIDTH'(`SPIO_DIR_RESET);
	localparam logic [WIDTH-1:0] LAT_RST = WIDTH'(`SPIO_LAT_RESET);

	logic [WIDTH-1:0] direction_reg_q;
	logic [WIDTH-1:0] output_latch_reg_q;
	logic [WIDTH-1:0] pin_sample_q;
	logic [WIDTH-1:0] periph_own;
	logic [WIDTH-1:0] pin_level_reg;
	spio_reg_t sel;
	logic wr_en;

	// Address decode, used by both the write and read paths.
	function automatic spio_reg_t decode(input logic [11:0] addr);
		unique case (addr)
			`SPIO_OFS_DIR: decode = SPIO_REG_DIR;
			`SPIO_OFS_LAT: decode = SPIO_REG_LAT;
			`SPIO_OFS_PIN: decode = SPIO_REG_PIN;
			default: decode = SPIO_REG_NONE;
		endcase
	endfunction

	assign sel = decode(PADDR_IN);
	assign wr_en = PSEL_IN && PENABLE_IN && PWRITE_IN;
	// Zero-wait slave; unmapped addresses answer with an error.
	assign PREADY_OUT = 1'b1;
	assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && (sel == SPIO_REG_NONE);

	////////////////////////////////////////////////////////////////////////////////
	// Direction register; reset sets implemented pins to input.
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			direction_reg_q <= DIR_RST & IMPL; // [R04] [R07]
		end else if (wr_en && sel == SPIO_REG_DIR) begin
			direction_reg_q <= PWDATA_IN[WIDTH-1:0] & IMPL; // [R07]
		end
	end

	// Output latch; pin-register writes land here too, no separate store exists.
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			output_latch_reg_q <= LAT_RST;
		end else if (wr_en && (sel == SPIO_REG_LAT || sel == SPIO_REG_PIN)) begin
			output_latch_reg_q <= PWDATA_IN[WIDTH-1:0] & IMPL; // [R05] [R06] [R07]
		end
	end

	// Pad sampler; this register stage is the one cycle of read-back latency.
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			pin_sample_q <= '0;
		end else begin
			pin_sample_q <= PAD_IN; // [R12]
		end
	end

	// Analog pins and unimplemented bits read low regardless of voltage.
	assign pin_level_reg = pin_sample_q & ~ANALOG_PIN_SELECT_IN & IMPL; // [R10] [R13] [R07]

	////////////////////////////////////////////////////////////////////////////////
	// Per-pin mux pair; pins not both shared and implemented skip it, so the port owns the pad.
	generate
		for (genvar i = 0; i < WIDTH; i++) begin : g_pin
			if (SHARED[i] && IMPL[i]) begin : g_shared
				assign periph_own[i] = PERIPH_EN_IN[i] & PERIPH_DRIVE_IN[i]; // [R01] [R02]
			end else begin : g_dedicated
				assign periph_own[i] = 1'b0; // [R09]
			end
			// Data mux and enable mux; direction one turns the port driver off.
			assign PAD_OUT[i] = periph_own[i] ? PERIPH_DATA_IN[i]
				: output_latch_reg_q[i]; // [R08]
			assign PAD_OE_OUT[i] = periph_own[i] ? 1'b1
				: (IMPL[i] & ~direction_reg_q[i]); // [R08] [R03]
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Read data registered at the setup cycle so it is valid in the access phase.
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			PRDATA_OUT <= '0;
		end else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
			unique case (sel)
				SPIO_REG_DIR: PRDATA_OUT <= 32'(direction_reg_q);
				SPIO_REG_LAT: PRDATA_OUT <= 32'(output_latch_reg_q); // [R05]
				SPIO_REG_PIN: PRDATA_OUT <= 32'(pin_level_reg); // [R06]
				SPIO_REG_NONE: PRDATA_OUT <= '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks on reset, on the state registers and on unimplemented pads.
	// These watch the stored state and the unimplemented pad enables, so they hold whatever the pads do.

	// Reset leaves every implemented pin undriven by the port.
	// The property is not disabled by reset because reset is its trigger.
	a_reset_inputs: assert property (@(posedge CLK_IN) // [R04]
		SRST_IN |=> (direction_reg_q == (DIR_RST & IMPL)))
		else $error("direction not input after reset");

	// Reset also clears the latch, so a later output turn-on drives a known level.
	// Without this a pin switched to output would show leftover data.
	a_reset_latch: assert property (@(posedge CLK_IN) // [R04]
		SRST_IN |=> (output_latch_reg_q == (LAT_RST & IMPL)))
		else $error("latch not cleared by reset");

	// Unimplemented bits never hold state in the direction register or the latch.
	// A write of all ones must not leave a stray bit behind.
	a_unimpl_zero: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // [R07]
		((direction_reg_q & ~IMPL) == '0) && ((output_latch_reg_q & ~IMPL) == '0))
		else $error("unimplemented bit set");

	// Unimplemented bits never drive their pad.
	// The pad cell of a missing pin must stay released at all times.
	a_unimpl_pad: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // [R07]
		(PAD_OE_OUT & ~IMPL) == '0)
		else $error("unimplemented pad driven");

	// Direction write lands one edge after the access phase.
	// Only implemented bits take the written value.
	a_dir_wr: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // [R03]
		(wr_en && sel == SPIO_REG_DIR) |=>
		direction_reg_q == ($past(PWDATA_IN[WIDTH-1:0]) & IMPL))
		else $error("direction write lost");

	// Pin-register write updates the latch.
	// There is no separate store behind the pin address.
	a_pin_wr_latch: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // [R06]
		(wr_en && sel == SPIO_REG_PIN) |=>
		output_latch_reg_q == ($past(PWDATA_IN[WIDTH-1:0]) & IMPL))
		else $error("pin write missed latch");

	// Latch write updates the latch.
	a_lat_wr: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // [R05]
		(wr_en && sel == SPIO_REG_LAT) |=>
		output_latch_reg_q == ($past(PWDATA_IN[WIDTH-1:0]) & IMPL))
		else $error("latch write lost");

	// A write to an unmapped address changes no state.
	// Software that strays off the map must not move a pin.
	a_bad_wr_keep: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // [R05]
		(wr_en && sel == SPIO_REG_NONE) |=>
		$stable(direction_reg_q) && $stable(output_latch_reg_q))
		else $error("unmapped write changed state");

	////////////////////////////////////////////////////////////////////////////////
	// Checks on the pin read path.
	// The sampler adds one cycle, which is the read-back gap software must leave.

	// The sampler follows the pad with one cycle of lag.
	// The first edge after reset is skipped, since the sampler was held at zero.
	a_pin_lag: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // [R12]
		!$past(SRST_IN) |-> (pin_sample_q == $past(PAD_IN)))
		else $error("pad sampler lag wrong");

	// Analog pins read low; other implemented pins show the pad level one cycle later.
	a_analog_low: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // [R10]
		!$past(SRST_IN) |-> ((pin_level_reg & ANALOG_PIN_SELECT_IN) == '0) &&
		(pin_level_reg == ($past(PAD_IN) & ~ANALOG_PIN_SELECT_IN & IMPL)))
		else $error("pin read wrong");

	// The analog select alone forces the read bit low, whatever the sampler holds.
	a_analog_force: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // [R13]
		((pin_level_reg & ANALOG_PIN_SELECT_IN) == '0) &&
		((pin_level_reg & ~IMPL) == '0))
		else $error("analog select ignored");

	////////////////////////////////////////////////////////////////////////////////
	// Checks on the pad multiplexers.
	// The pad outputs are combinational, so they are compared in the same cycle.

	// Port output follows direction and latch when the peripheral is idle.
	a_port_drive: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // [R02]
		((PERIPH_DRIVE_IN & SHARED) == '0) |->
		(PAD_OE_OUT == (IMPL & ~direction_reg_q)) && (PAD_OUT == output_latch_reg_q))
		else $error("port drive wrong");

	// Per pin, an idle peripheral leaves data and enable to the port.
	// This covers the mixed case where only some peripherals drive.
	a_idle_bits: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // [R02]
		(((PAD_OUT ^ output_latch_reg_q) & ~periph_own) == '0) &&
		(((PAD_OE_OUT ^ (IMPL & ~direction_reg_q)) & ~periph_own) == '0))
		else $error("idle pin not port driven");

	// Direction one releases a pad that the peripheral does not own.
	a_dir_input: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // [R03]
		(PAD_OE_OUT & direction_reg_q & ~periph_own) == '0)
		else $error("input pin driven");

	// Direction zero drives an implemented pad, from the latch when the peripheral does not own it.
	a_dir_output: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // [R03]
		((~PAD_OE_OUT & ~direction_reg_q & IMPL) == '0))
		else $error("output pin released");

	// Active peripheral owns shared pads.
	a_periph_own: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // [R01]
		((PAD_OE_OUT & periph_own) == periph_own) &&
		((PAD_OUT & periph_own) == (PERIPH_DATA_IN & periph_own)))
		else $error("peripheral lost pad");

	// Ownership needs both enable and drive on a shared, implemented pin.
	// An enabled peripheral that is not driving must not take the pad.
	a_own_terms: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // [R08]
		periph_own == (PERIPH_EN_IN & PERIPH_DRIVE_IN & SHARED & IMPL))
		else $error("mux select wrong");

	// Dedicated pins never pass to the peripheral.
	a_dedicated: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // [R09]
		(periph_own & ~(SHARED & IMPL)) == '0)
		else $error("dedicated pin muxed");

	////////////////////////////////////////////////////////////////////////////////
	// Checks on the bus side.
	// Read data is captured at the setup edge and must stand through the access phase.

	// A read in the access phase shows the direction register.
	a_dir_read: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // [R03]
		(PSEL_IN && !PENABLE_IN && !PWRITE_IN && sel == SPIO_REG_DIR) |=>
		PRDATA_OUT == 32'($past(direction_reg_q)))
		else $error("direction read wrong");

	// A latch read returns the latch, not the pins.
	a_lat_read: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // [R05]
		(PSEL_IN && !PENABLE_IN && !PWRITE_IN && sel == SPIO_REG_LAT) |=>
		PRDATA_OUT == 32'($past(output_latch_reg_q)))
		else $error("latch read wrong");

	// A pin read returns the sampled, masked pin levels.
	a_pin_read: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // [R06]
		(PSEL_IN && !PENABLE_IN && !PWRITE_IN && sel == SPIO_REG_PIN) |=>
		PRDATA_OUT == 32'($past(pin_level_reg)))
		else $error("pin read data wrong");

	// Read data never shows a bit that the variant lacks.
	a_read_unimpl: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // [R07]
		(PRDATA_OUT & ~32'(IMPL)) == '0)
		else $error("unimplemented bit read");

	// Read data stands until the next read setup, so a slow master still sees it.
	a_read_hold: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // [R05]
		!(PSEL_IN && !PENABLE_IN && !PWRITE_IN) |=> $stable(PRDATA_OUT))
		else $error("read data moved");

	// Unmapped accesses answer with an error in the access phase.
	a_bad_addr_err: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // [R07]
		(PSEL_IN && PENABLE_IN && sel == SPIO_REG_NONE) |-> PSLVERR_OUT)
		else $error("unmapped access not refused");

	// Mapped accesses never raise the error.
	a_good_addr_ok: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // [R05]
		(sel != SPIO_REG_NONE) |-> !PSLVERR_OUT)
		else $error("mapped access refused");
endmodule

/* File: tb/spio_pad_model.sv */
// Pad wire model: what the outside world sees and feeds back to the port.
`timescale 1ns/1ps
module spio_pad_model (
	// Port pad drive.
	input wire logic [15:0] pad_out_in,
	input wire logic [15:0] pad_oe_in,
	// Level of the outside source on released pads.
	input wire logic [15:0] ext_in,
	// Resolved pad level.
	output logic [15:0] level_out
);
	// A driven pad shows its driver; a released one follows the outside source.
	assign level_out = (pad_oe_in & pad_out_in) | (~pad_oe_in & ext_in);
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the shared parallel I/O port.
`timescale 1ns/1ps
`include "spio_defines.svh"
module tb;
	localparam logic [15:0] IM = 16'h1fff;
	localparam logic [15:0] SM = 16'hff0f;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, rdy, perr, er;
	logic [11:0] pa = 12'h0;
	logic [31:0] pwd = 32'h0, prd, r;
	logic [15:0] lvl, po, poe, en = 16'h0, drv = 16'h0, pd = 16'h0, ana = 16'h0, ext = 16'h0;
	logic [15:0] s, dm, lm, own, e;
	int err_count = 0, compares = 0;
	// Free-running 200 MHz clock.
	always #2.5 clk = ~clk;
	spio_port #(.WIDTH(16), .IMPL_MASK(IM), .SHARED_MASK(SM)) DUT (.CLK_IN(clk),
		.SRST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(pa),
		.PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(rdy), .PSLVERR_OUT(perr),
		.PAD_IN(lvl), .PAD_OUT(po), .PAD_OE_OUT(poe), .PERIPH_EN_IN(en),
		.PERIPH_DRIVE_IN(drv), .PERIPH_DATA_IN(pd), .ANALOG_PIN_SELECT_IN(ana));
	spio_pad_model pads (.pad_out_in(po), .pad_oe_in(poe), .ext_in(ext), .level_out(lvl));
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic print_verdict();
		if (err_count == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// One APB transfer; the request holds until ready is sampled high.
	task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= {16'h0, d};
		@(posedge clk);
		pen <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (rdy === 1'b1) break;
		end
		if (n == 20) begin
			err_count++;
			print_verdict();
		end
		r = prd;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: reset values, random pin traffic, then an unmapped write and an unmapped read.
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		s = 16'hf7e9;
		apb(1'b0, `SPIO_OFS_DIR, 16'h0);
		chk("dir reset", r, {16'h0, `SPIO_DIR_RESET & IM});
		apb(1'b0, `SPIO_OFS_LAT, 16'h0);
		chk("lat reset", r, 32'h0);
		chk("slverr", {31'h0, er}, 32'h0);
		for (int i = 0; i < 24; i++) begin
			s = lfsr(s);
			dm = s;
			s = lfsr(s);
			lm = s;
			s = lfsr(s);
			en <= s;
			drv <= ~lm ^ dm;
			pd <= lfsr(s);
			ana <= (s ^ lm) & dm;
			ext <= ~s;
			apb(1'b1, `SPIO_OFS_DIR, dm);
			apb(1'b1, i[0] ? `SPIO_OFS_PIN : `SPIO_OFS_LAT, lm);
			apb(1'b0, `SPIO_OFS_LAT, 16'h0);
			chk("lat", r, {16'h0, lm & IM});
			apb(1'b0, `SPIO_OFS_DIR, 16'h0);
			chk("dir", r, {16'h0, dm & IM});
			own = en & drv & SM & IM;
			e = (own | ~dm) & IM;
			chk("oe", {16'h0, poe & IM}, {16'h0, e});
			chk("oe unimpl", {16'h0, poe & ~IM}, 32'h0);
			chk("dout", {16'h0, po & e}, {16'h0, ((own & pd) | (~own & lm)) & e});
			apb(1'b0, `SPIO_OFS_PIN, 16'h0);
			s = (e & ((own & pd) | (~own & lm))) | (~e & ext);
			chk("pin", r, {16'h0, s & ~ana & IM});
		end
		apb(1'b1, `SPIO_OFS_PERIPH, 16'hffff);
		chk("bad wr err", {31'h0, er}, 32'h1);
		apb(1'b0, `SPIO_OFS_PERIPH, 16'h0);
		chk("bad rd", r, 32'h0);
		apb(1'b0, `SPIO_OFS_LAT, 16'h0);
		chk("lat kept", r, {16'h0, lm & IM});
		print_verdict();
	end
endmodule
